// [rtl/flash_self_program_cfg.svh]
// Constants of the flash self-programming controller: register addresses,
// field positions, reset values and timing figures.
// Assumes a 100 MHz CPU clock; times are held in ns as printed.
`ifndef FLASH_SELF_PROGRAM_CFG_SVH
`define FLASH_SELF_PROGRAM_CFG_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define ADDR_PROT_CMD   16'hffa0
`define ADDR_ERR_STAT   16'hffa1
`define ADDR_MODE_CTRL  16'hffa2
`define ADDR_PROG_CMD   16'hffa3
`define ADDR_PTR_LO     16'hffa4
`define ADDR_PTR_HI     16'hffa5
`define ADDR_CMP_LO     16'hffa6
`define ADDR_CMP_HI     16'hffa7
`define ADDR_WR_BUF     16'hffa8

// ****************************************************************
// Fields and values
// ****************************************************************
`define UNLOCK_KEY      8'ha5
`define BLANK_VAL       8'hff
`define STAT_PROT_BIT   0
`define STAT_VFY_BIT    1
`define STAT_WEP_BIT    2
`define MODE_BIT        0
`define PROT_LSB        2
`define PROT_MSB        6
`define RST_BYTE        8'h00

// ****************************************************************
// Timing, in ns as printed, and cycle counts
// ****************************************************************
`define CLK_NS          10
`define T_VFY_BLOCK_NS  6_800_000
`define T_VFY_BYTE_NS   27_000
`define T_ERASE_NS      8_500_000
`define T_BLANK_NS      480_000
`define T_WRITE_NS      150_000
`define T_FIRST_REL_NS  10_000
`define FIRST_REL_CLKS  2
`define CYC_OF(ns)      ((ns) / `CLK_NS)

`endif

// [rtl/flash_self_program_ctrl.sv]
// Flash self-programming controller: mode control with unlock sequence,
// error status, command launch on HALT and timed command execution.
// Assumes a CPU store/load port on ref_clk_i and a flash macro whose read
// data follows flash_addr_o combinationally on the same clock.
`default_nettype none
`include "flash_self_program_cfg.svh"

module flash_self_program_ctrl
  import flash_self_program_pkg::*;
#(
  parameter int unsigned VFY_BLOCK_CYC = `CYC_OF(`T_VFY_BLOCK_NS),
  parameter int unsigned ERASE_CYC     = `CYC_OF(`T_ERASE_NS),
  parameter int unsigned BLANK_CYC     = `CYC_OF(`T_BLANK_NS),
  parameter int unsigned WRITE_CYC     = `CYC_OF(`T_WRITE_NS)
) (
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  input  wire logic [15:0] reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_we_i,
  input  wire logic        reg_re_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic        halt_i,
  input  wire logic        wake_i,
  output logic             halt_hold_o,
  output logic             halt_release_o,
  output logic             standby_o,
  output logic             pin_hold_o,
  input  wire logic [7:0]  irq_req_i,
  output logic      [7:0]  irq_service_o,
  output logic      [7:0]  irq_pending_o,
  input  wire logic [7:0]  protect_byte_i,
  output logic      [11:0] flash_addr_o,
  output logic      [7:0]  flash_wdata_o,
  input  wire logic [7:0]  flash_rdata_i,
  input  wire logic        flash_margin_ok_i,
  output logic             flash_write_o,
  output logic             flash_erase_o
);

  localparam logic [19:0] VFY_BYTE_CYC = 20'(`CYC_OF(`T_VFY_BYTE_NS));
  localparam logic [19:0] FIRST_CYC =
    20'(`CYC_OF(`T_FIRST_REL_NS) + `FIRST_REL_CLKS);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Protected when the block lies below the boundary set by the
  // protect bits; a set top bit leaves every block open.
  function automatic logic blk_protected(input logic [3:0] blk,
                                         input logic [4:0] prot);
    logic [5:0] bound;
    bound = 6'(2 * (16 - {2'b00, prot[3:0]}));
    return !prot[4] && ({2'b00, blk} < bound);
  endfunction

  function automatic logic reg_hit(input logic [15:0] a,
                                   input logic [15:0] r);
    return reg_we_i && (a == r);
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  seq_state_t  st_q, st_d;
  logic        mode_q, mode_d;
  logic [4:0]  prot_q, prot_d;
  logic        prot_ld_q, prot_ld_d;
  logic [1:0]  seq_q, seq_d;
  logic        seq_val_q, seq_val_d;
  logic [2:0]  pfs_q, pfs_d;
  logic [2:0]  cmd_q, cmd_d;
  logic [15:0] ptr_q, ptr_d;
  logic [15:0] cmp_q, cmp_d;
  logic [7:0]  wbuf_q, wbuf_d;
  logic [19:0] cnt_q, cnt_d;
  logic        first_q, first_d;
  logic        scan_q, scan_d;
  logic [7:0]  pend_q, pend_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        wr_q, wr_d;
  logic        er_q, er_d;
  logic        w_mode, w_pfs;
  logic [2:0]  pfs_set;
  logic [19:0] fwait_q, fwait_d;

  assign w_mode = reg_hit(reg_addr_i, `ADDR_MODE_CTRL);
  assign w_pfs  = reg_hit(reg_addr_i, `ADDR_ERR_STAT);

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    st_d      = st_q;
    mode_d    = mode_q;
    prot_d    = prot_q;
    prot_ld_d = 1'b1;
    seq_d     = seq_q;
    seq_val_d = seq_val_q;
    pfs_set   = 3'b000;
    cmd_d     = cmd_q;
    ptr_d     = ptr_q;
    cmp_d     = cmp_q;
    wbuf_d    = wbuf_q;
    cnt_d     = cnt_q;
    first_d   = first_q;
    scan_d    = scan_q;
    wr_d      = 1'b0;
    er_d      = 1'b0;
    rdata_d   = `RST_BYTE;
    // Protect bits are caught once, the first cycle after release.
    if (!prot_ld_q) begin
      prot_d = protect_byte_i[`PROT_MSB:`PROT_LSB];
    end
    // Any store that breaks the four-store sequence aborts it.
    if (reg_we_i) begin
      unique case (seq_q)
        2'd0: begin
          if (reg_addr_i == `ADDR_PROT_CMD) begin
            if (reg_wdata_i == `UNLOCK_KEY) seq_d = 2'd1;
            else pfs_set[`STAT_PROT_BIT] = 1'b1;
          end else if (w_mode) begin
            pfs_set[`STAT_PROT_BIT] = 1'b1;
          end
        end
        2'd1: begin
          seq_val_d = reg_wdata_i[`MODE_BIT];
          seq_d     = w_mode ? 2'd2 : 2'd0;
          pfs_set[`STAT_PROT_BIT] = !w_mode;
        end
        2'd2: begin
          if (w_mode && reg_wdata_i[`MODE_BIT] == !seq_val_q) begin
            seq_d = 2'd3;
          end else begin
            seq_d = 2'd0;
            pfs_set[`STAT_PROT_BIT] = 1'b1;
          end
        end
        2'd3: begin
          seq_d = 2'd0;
          if (w_mode && reg_wdata_i[`MODE_BIT] == seq_val_q) begin
            mode_d  = seq_val_q;
            first_d = seq_val_q;
          end else begin
            pfs_set[`STAT_PROT_BIT] = 1'b1;
          end
        end
      endcase
      if (reg_addr_i == `ADDR_PROG_CMD) cmd_d = reg_wdata_i[2:0];
      if (reg_addr_i == `ADDR_WR_BUF) wbuf_d = reg_wdata_i;
      if (reg_addr_i == `ADDR_CMP_LO) cmp_d[7:0] = reg_wdata_i;
      if (reg_addr_i == `ADDR_CMP_HI) cmp_d[15:8] = reg_wdata_i;
    end
    // Pointers creep toward the compare value while idle, so software
    // has to load them again just before each HALT.
    if (st_q == ST_IDLE && ptr_q != cmp_q) begin
      ptr_d = ptr_q + 16'd1;
    end
    if (reg_hit(reg_addr_i, `ADDR_PTR_LO)) ptr_d[7:0] = reg_wdata_i;
    if (reg_hit(reg_addr_i, `ADDR_PTR_HI)) ptr_d[15:8] = reg_wdata_i;
    unique case (st_q)
      ST_IDLE: begin
        if (halt_i && !mode_q) begin
          st_d = ST_STBY;
        end else if (halt_i && first_q) begin
          st_d    = ST_FIRST;
          first_d = 1'b0;
          cnt_d   = FIRST_CYC - 20'd1;
        end else if (halt_i) begin
          // External security is not consulted; an illegal code, a protected
          // block or a write needing a 0-to-1 bit change refuses a command.
          st_d   = ST_RUN;
          scan_d = 1'b0;
          if (!(cmd_q inside {CMD_VFY_BLOCK, CMD_VFY_BYTE, CMD_ERASE,
                              CMD_BLANK, CMD_WRITE})) begin
            st_d = ST_DONE;
            pfs_set[`STAT_WEP_BIT] = 1'b1;
          end else if (blk_protected(ptr_q[11:8], prot_q)) begin
            st_d = ST_DONE;
            pfs_set[`STAT_WEP_BIT] = 1'b1;
          end else begin
            unique case (prog_cmd_t'(cmd_q))
              CMD_VFY_BLOCK: begin
                cnt_d  = 20'(VFY_BLOCK_CYC - 1);
                scan_d = 1'b1;
              end
              CMD_VFY_BYTE: cnt_d = VFY_BYTE_CYC - 20'd1;
              CMD_ERASE: begin
                cnt_d = 20'(ERASE_CYC - 1);
                er_d  = 1'b1;
              end
              CMD_BLANK: begin
                cnt_d  = 20'(BLANK_CYC - 1);
                scan_d = 1'b1;
              end
              default: begin
                cnt_d = 20'(WRITE_CYC - 1);
                if ((~flash_rdata_i & wbuf_q) != 8'h00) begin
                  st_d = ST_DONE;
                  pfs_set[`STAT_WEP_BIT] = 1'b1;
                end else begin
                  wr_d = 1'b1;
                end
              end
            endcase
          end
        end
      end
      ST_FIRST: begin
        cnt_d = cnt_q - 20'd1;
        if (cnt_q == 20'd0) st_d = ST_DONE;
      end
      ST_RUN: begin
        cnt_d = cnt_q - 20'd1;
        if (scan_q) begin
          if (cmd_q == CMD_BLANK) begin
            pfs_set[`STAT_VFY_BIT] = flash_rdata_i != `BLANK_VAL;
          end else begin
            pfs_set[`STAT_VFY_BIT] = !flash_margin_ok_i;
          end
          if (ptr_q == cmp_q) scan_d = 1'b0;
          else ptr_d = ptr_q + 16'd1;
        end
        if (cnt_q == 20'd0) begin
          st_d = ST_DONE;
          if (cmd_q == CMD_VFY_BYTE) begin
            pfs_set[`STAT_VFY_BIT] = !flash_margin_ok_i;
            if (ptr_q != cmp_q) begin
              st_d  = ST_RUN;
              ptr_d = ptr_q + 16'd1;
              cnt_d = VFY_BYTE_CYC - 20'd1;
            end
          end
        end
      end
      ST_DONE: st_d = ST_IDLE;
      ST_STBY: if (wake_i) st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
    // A hardware set in the cycle of a software clear wins.
    pfs_d = pfs_q;
    if (w_pfs) pfs_d = pfs_q & reg_wdata_i[2:0];
    pfs_d = pfs_d | pfs_set;
    if (reg_re_i) begin
      unique case (reg_addr_i)
        `ADDR_ERR_STAT:  rdata_d = {5'b00000, pfs_q};
        `ADDR_MODE_CTRL: rdata_d = {1'b0, prot_q, 1'b0, mode_q};
        `ADDR_PROG_CMD:  rdata_d = {5'b00000, cmd_q};
        `ADDR_PTR_LO:    rdata_d = ptr_q[7:0];
        `ADDR_PTR_HI:    rdata_d = ptr_q[15:8];
        `ADDR_CMP_LO:    rdata_d = cmp_q[7:0];
        `ADDR_CMP_HI:    rdata_d = cmp_q[15:8];
        `ADDR_WR_BUF:    rdata_d = wbuf_q;
        default:         rdata_d = `RST_BYTE;
      endcase
    end
    // Requests caught in the mode are offered once it has ended.
    pend_d = mode_q ? (pend_q | irq_req_i) : 8'h00;
    // The first-halt wait is longer than a delay range may span, so its
    // length is counted here and bounded by an assertion.
    fwait_d = (st_q == ST_FIRST) ? fwait_q + 20'd1 : 20'h0_0000;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q      <= ST_IDLE;
      mode_q    <= 1'b0;
      prot_q    <= 5'h00;
      prot_ld_q <= 1'b0;
      seq_q     <= 2'd0;
      seq_val_q <= 1'b0;
      pfs_q     <= 3'b000;
      cmd_q     <= 3'b000;
      ptr_q     <= 16'h0000;
      cmp_q     <= 16'h0000;
      wbuf_q    <= `RST_BYTE;
      cnt_q     <= 20'h0_0000;
      first_q   <= 1'b0;
      scan_q    <= 1'b0;
      pend_q    <= 8'h00;
      rdata_q   <= `RST_BYTE;
      wr_q      <= 1'b0;
      er_q      <= 1'b0;
      fwait_q   <= 20'h0_0000;
    end else begin
      st_q      <= st_d;
      mode_q    <= mode_d;
      prot_q    <= prot_d;
      prot_ld_q <= prot_ld_d;
      seq_q     <= seq_d;
      seq_val_q <= seq_val_d;
      pfs_q     <= pfs_d;
      cmd_q     <= cmd_d;
      ptr_q     <= ptr_d;
      cmp_q     <= cmp_d;
      wbuf_q    <= wbuf_d;
      cnt_q     <= cnt_d;
      first_q   <= first_d;
      scan_q    <= scan_d;
      pend_q    <= pend_d;
      rdata_q   <= rdata_d;
      wr_q      <= wr_d;
      er_q      <= er_d;
      fwait_q   <= fwait_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata_o    = rdata_q;
  assign halt_hold_o    = st_q == ST_RUN || st_q == ST_FIRST;
  assign halt_release_o = st_q == ST_DONE;
  assign standby_o      = st_q == ST_STBY;
  assign pin_hold_o     = mode_q || st_q == ST_STBY;
  assign irq_service_o  = mode_q ? 8'h00 : (irq_req_i | pend_q);
  assign irq_pending_o  = pend_q;
  assign flash_addr_o   = ptr_q[11:0];
  assign flash_wdata_o  = er_q ? `BLANK_VAL : wbuf_q;
  assign flash_write_o  = wr_q;
  assign flash_erase_o  = er_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  property p_no_irq;
    mode_q |-> irq_service_o == 8'h00;
  endproperty
  a_no_irq: assert property (p_no_irq)
    else $error("interrupt serviced in self-program mode");

  property p_irq_pend;
    mode_q && irq_req_i[0] |=> irq_pending_o[0];
  endproperty
  a_irq_pend: assert property (p_irq_pend)
    else $error("interrupt request not held pending");

  property p_first_rel;
    st_q == ST_FIRST |-> fwait_q < FIRST_CYC;
  endproperty
  a_first_rel: assert property (p_first_rel)
    else $error("first halt not released in time");

  property p_bad_mode_write;
    reg_we_i && w_mode && seq_q == 2'd0
      |=> pfs_q[`STAT_PROT_BIT] && $stable(mode_q);
  endproperty
  a_bad_mode_write: assert property (p_bad_mode_write)
    else $error("unguarded mode write not refused");

  property p_unlock_apply;
    reg_we_i && w_mode && seq_q == 2'd3 &&
      reg_wdata_i[`MODE_BIT] == seq_val_q
      |=> mode_q == $past(reg_wdata_i[`MODE_BIT]);
  endproperty
  a_unlock_apply: assert property (p_unlock_apply)
    else $error("fourth store did not set the mode");

  property p_stall;
    st_q == ST_RUN |-> halt_hold_o && !halt_release_o;
  endproperty
  a_stall: assert property (p_stall)
    else $error("CPU not held during a command");

  property p_bad_cmd;
    st_q == ST_IDLE && halt_i && mode_q && !first_q && cmd_q == 3'b111
      |=> pfs_q[`STAT_WEP_BIT] && halt_release_o;
  endproperty
  a_bad_cmd: assert property (p_bad_cmd)
    else $error("illegal command not aborted with error");

  property p_normal_halt;
    st_q == ST_IDLE && halt_i && !mode_q |=> standby_o && !flash_erase_o;
  endproperty
  a_normal_halt: assert property (p_normal_halt)
    else $error("normal mode HALT did not enter standby");

  property p_erase_blank;
    flash_erase_o |-> flash_wdata_o == `BLANK_VAL && halt_hold_o;
  endproperty
  a_erase_blank: assert property (p_erase_blank)
    else $error("erase not driving blank value");

endmodule : flash_self_program_ctrl
`default_nettype wire

// [rtl/flash_self_program_pkg.sv]
// Types of the flash self-programming controller.
// Assumes nothing of its surroundings.
`default_nettype none
package flash_self_program_pkg;
  typedef enum logic [2:0] {
    CMD_NONE      = 3'b000,
    CMD_VFY_BLOCK = 3'b001,
    CMD_VFY_BYTE  = 3'b010,
    CMD_ERASE     = 3'b011,
    CMD_BLANK     = 3'b100,
    CMD_WRITE     = 3'b101
  } prog_cmd_t;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FIRST = 3'b001,
    ST_RUN   = 3'b010,
    ST_DONE  = 3'b011,
    ST_STBY  = 3'b100
  } seq_state_t;
endpackage : flash_self_program_pkg
`default_nettype wire

// [tb/flash_array_model.sv]
// Behavioural flash array standing behind the controller's macro port.
// Assumes one clock; read data follows the address with no delay.
`default_nettype none

module flash_array_model (
  input  wire logic        ref_clk_i,
  input  wire logic [11:0] flash_addr_i,
  input  wire logic [7:0]  flash_wdata_i,
  input  wire logic        flash_write_i,
  input  wire logic        flash_erase_i,
  output logic      [7:0]  flash_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem_q [4096];

  // The last byte of block 5 is left programmed so a blank check can fail.
  initial begin
    foreach (mem_q[i]) begin
      mem_q[i] = 8'hff;
    end
    mem_q[12'h5ff] = 8'h00;
  end

  assign flash_rdata_o = mem_q[flash_addr_i];

  always @(posedge ref_clk_i) begin
    if (flash_write_i) begin
      // Programming can only clear bits, as a real cell does.
      mem_q[flash_addr_i] <= mem_q[flash_addr_i] & flash_wdata_i;
    end
    if (flash_erase_i) begin
      for (int a = 0; a < 256; a++) begin
        mem_q[{flash_addr_i[11:8], a[7:0]}] <= 8'hff;
      end
    end
  end
endmodule // flash_array_model

`default_nettype wire

// [tb/tb_flash_self_program_ctrl.sv]
// Self-checking bench of the flash self-programming controller.
// Assumes the package, the controller and the flash array model are
// compiled first; the bench plays the CPU side.
`default_nettype none

module tb_flash_self_program_ctrl;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Set-up
  // ****************************************************************
  // Shortened command counts keep the run brief; the byte verify is fixed.
  localparam int VB = 20;
  localparam int ER = 30;
  localparam int BL = 10;
  localparam int WR = 8;
  localparam int VY = 2700;
  localparam logic [7:0] PROT_BYTE = 8'hbb;
  localparam logic [7:0] MODE0 = {1'b0, PROT_BYTE[6:2], 2'b00};

  logic        ref_clk_i, nrst_i, reg_we_i, reg_re_i, halt_i, wake_i;
  logic [15:0] reg_addr_i;
  logic [7:0]  reg_wdata_i, reg_rdata_o, irq_req_i, irq_service_o;
  logic [7:0]  irq_pending_o, flash_wdata_o, flash_rdata_i;
  logic        halt_hold_o, halt_release_o, standby_o, pin_hold_o;
  logic        flash_write_o, flash_erase_o, margin_ok;
  logic [11:0] flash_addr_o;
  int          errors = 0;
  int          cmp_count = 0;
  int          cycles = 0;

  flash_self_program_ctrl #(
    .VFY_BLOCK_CYC (VB),
    .ERASE_CYC     (ER),
    .BLANK_CYC     (BL),
    .WRITE_CYC     (WR)
  ) i_dut (
    .ref_clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i,
    .reg_rdata_o, .halt_i, .wake_i, .halt_hold_o, .halt_release_o,
    .standby_o, .pin_hold_o, .irq_req_i, .irq_service_o, .irq_pending_o,
    .protect_byte_i (PROT_BYTE), .flash_addr_o, .flash_wdata_o,
    .flash_rdata_i, .flash_margin_ok_i (margin_ok), .flash_write_o,
    .flash_erase_o
  );

  flash_array_model i_flash (
    .ref_clk_i     (ref_clk_i),
    .flash_addr_i  (flash_addr_o),
    .flash_wdata_i (flash_wdata_o),
    .flash_write_i (flash_write_o),
    .flash_erase_i (flash_erase_o),
    .flash_rdata_o (flash_rdata_i)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic give_verdict();
    if (errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic check_rng(input string what, input int lo, hi, seen);
    cmp_count++;
    if (seen < lo || seen > hi) begin
      errors++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_we_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_we_i    <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp,
                    input string what);
    @(posedge ref_clk_i);
    reg_re_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_re_i   <= 1'b0;
    #1 check(what, exp, reg_rdata_o);
  endtask

  task automatic unlock(input logic v);
    wr(16'hffa0, 8'ha5);
    wr(16'hffa2, {7'b0, v});
    wr(16'hffa2, {7'b0, ~v});
    wr(16'hffa2, {7'b0, v});
  endtask

  // A halt is launched and held until released; the CPU must see no interrupt
  // all the while, and must stay held when chk_hold is set.
  task automatic run_halt(input int lo, hi, nw, ne, input logic chk_hold);
    int n;
    int w;
    int e;
    int bad;
    n = 0;
    w = 0;
    e = 0;
    bad = 0;
    @(posedge ref_clk_i);
    halt_i <= 1'b1;
    @(posedge ref_clk_i);
    halt_i <= 1'b0;
    #1;
    while (halt_release_o !== 1'b1 && n < 20000) begin
      w += (flash_write_o === 1'b1);
      e += (flash_erase_o === 1'b1);
      bad += chk_hold && (halt_hold_o !== 1'b1);
      bad += (irq_service_o !== 8'h00);
      @(posedge ref_clk_i);
      #1 n++;
    end
    check_rng("halt release latency", lo, hi, n);
    check("write pulses", nw[15:0], w[15:0]);
    check("erase pulses", ne[15:0], e[15:0]);
    check("cycles not held or irq served", 16'h0000, bad[15:0]);
    check("hold at release", 16'h0000, {15'b0, halt_hold_o});
  endtask

  task automatic do_cmd(input logic [2:0] code, input logic [15:0] p, c,
                        input int lo, hi, nw, ne, input logic [7:0] st);
    wr(16'hffa3, {5'b0, code});
    wr(16'hffa4, 8'h00);
    wr(16'hffa6, c[7:0]);
    wr(16'hffa7, c[15:8]);
    wr(16'hffa5, p[15:8]);
    wr(16'hffa4, p[7:0]);
    run_halt(lo, hi, nw, ne, st == 8'h00);
    rd(16'hffa1, st, "status after command");
    wr(16'hffa1, 8'h00);
  endtask

  task automatic halt_standby();
    @(posedge ref_clk_i);
    halt_i <= 1'b1;
    @(posedge ref_clk_i);
    halt_i <= 1'b0;
    #1 check("standby", 16'h0001, {15'b0, standby_o});
    check("pins held in standby", 16'h0001, {15'b0, pin_hold_o});
    check("no command release", 16'h0000, {15'b0, halt_release_o});
    @(posedge ref_clk_i);
    wake_i <= 1'b1;
    @(posedge ref_clk_i);
    wake_i <= 1'b0;
    #1 check("standby after wake", 16'h0000, {15'b0, standby_o});
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      give_verdict();
    end
  end

  initial begin
    nrst_i = 1'b0;
    {reg_we_i, reg_re_i, halt_i, wake_i} = 4'b0;
    reg_addr_i = 16'h0000;
    reg_wdata_i = 8'h00;
    irq_req_i = 8'h00;
    margin_ok = 1'b1;
    repeat (3) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    @(posedge ref_clk_i);
    rd(16'hffa2, MODE0, "mode after reset");
    rd(16'hffa1, 8'h00, "status after reset");
    rd(16'hffb0, 8'h00, "unmapped read");
    halt_standby();
    wr(16'hffa2, 8'h01);
    rd(16'hffa2, MODE0, "mode after stray store");
    rd(16'hffa1, 8'h01, "status after stray store");
    wr(16'hffa1, 8'h00);
    rd(16'hffa1, 8'h00, "status after clear");
    wr(16'hffa0, 8'h5a);
    rd(16'hffa1, 8'h01, "status after bad key");
    wr(16'hffa1, 8'h00);
    wr(16'hffa0, 8'ha5);
    wr(16'hffa2, 8'h01);
    wr(16'hffa2, 8'h01);
    wr(16'hffa2, 8'h01);
    rd(16'hffa2, MODE0, "mode after bad inverse");
    rd(16'hffa1, 8'h01, "status after bad inverse");
    wr(16'hffa1, 8'h00);
    wr(16'hffa0, 8'ha5);
    wr(16'hffa3, 8'h00);
    rd(16'hffa1, 8'h01, "status after foreign store");
    wr(16'hffa1, 8'h00);
    irq_req_i <= 8'h05;
    wr(16'hffa3, 8'h00);
    unlock(1'b1);
    #1 check("pins held in mode", 16'h0001, {15'b0, pin_hold_o});
    check("irq service in mode", 16'h0000, {8'h00, irq_service_o});
    rd(16'hffa2, MODE0 | 8'h01, "mode after entry");
    check("irq pending", 16'h0005, {8'h00, irq_pending_o});
    run_halt(1, 1003, 0, 0, 1'b1);
    repeat (800) @(posedge ref_clk_i);
    wr(16'hffa8, 8'h5a);
    do_cmd(3'b101, 16'h0400, 16'h0400, WR, WR + 1, 1, 0, 8'h00);
    check("written byte", 16'h005a, {8'h00, i_flash.mem_q[12'h400]});
    wr(16'hffa8, 8'hff);
    do_cmd(3'b101, 16'h0400, 16'h0400, 0, 1, 0, 0, 8'h04);
    do_cmd(3'b001, 16'h0400, 16'h0400, VB, VB + 1, 0, 0, 8'h00);
    margin_ok <= 1'b0;
    do_cmd(3'b001, 16'h0400, 16'h0400, VB, VB + 1, 0, 0, 8'h02);
    margin_ok <= 1'b1;
    do_cmd(3'b010, 16'h0400, 16'h0400, VY, VY + 1, 0, 0, 8'h00);
    do_cmd(3'b011, 16'h0400, 16'h0400, ER, ER + 1, 0, 1, 8'h00);
    check("erased byte", 16'h00ff, {8'h00, i_flash.mem_q[12'h400]});
    do_cmd(3'b100, 16'h0400, 16'h04ff, BL, BL + 1, 0, 0, 8'h00);
    // The pointer creeps while idle, so the scan starts near the last
    // byte to reach the programmed one within the shortened count.
    do_cmd(3'b100, 16'h05f8, 16'h05ff, BL, BL + 1, 0, 0, 8'h02);
    do_cmd(3'b011, 16'h0200, 16'h0200, 0, 1, 0, 0, 8'h04);
    for (int c = 6; c < 8; c++) begin
      do_cmd(c[2:0], 16'h0400, 16'h0400, 0, 1, 0, 0, 8'h04);
    end
    irq_req_i <= 8'h00;
    wr(16'hffa3, 8'h00);
    unlock(1'b0);
    #1 check("irq offered at exit", 16'h0005, {8'h00, irq_service_o});
    repeat (2) @(posedge ref_clk_i);
    #1 check("pins after exit", 16'h0000, {15'b0, pin_hold_o});
    check("irq service after exit", 16'h0000, {8'h00, irq_service_o});
    check("pending after exit", 16'h0000, {8'h00, irq_pending_o});
    rd(16'hffa2, MODE0, "mode after exit");
    halt_standby();
    give_verdict();
  end
endmodule // tb_flash_self_program_ctrl

`default_nettype wire
